// File: src/ldc_pkg.sv
/*
 * ldc_pkg: constants and carrier types for the two-channel led dimming and soft-start block.
 * assumes a 20 mhz main clock and a plain single-cycle register port.
 */
package ldc_pkg;
    // ********************************
    // timing
    // ********************************
    localparam int CLK_PERIOD_PS = 50000;
    localparam int BLANK_LONG_PS = 150000;
    localparam int BLANK_SHORT_PS = 75000;
    // least times: round up
    localparam int BLANK_LONG_CYC = (BLANK_LONG_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int BLANK_SHORT_CYC = (BLANK_SHORT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [3:0] BLANK_LONG_CNT = 4'(BLANK_LONG_CYC);
    localparam logic [3:0] BLANK_SHORT_CNT = 4'(BLANK_SHORT_CYC);

    // ********************************
    // register map (byte offsets)
    // ********************************
    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_CH_BASE = 8'h10;
    localparam logic [7:0] ADDR_CH_STRIDE = 8'h20;
    localparam logic [7:0] OFS_CHCFG = 8'h00;
    localparam logic [7:0] OFS_LIMIT = 8'h04;
    localparam logic [7:0] OFS_SETPT = 8'h08;
    localparam logic [7:0] OFS_DUTYH = 8'h0c;
    localparam logic [7:0] OFS_DUTYL = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // global config bits
    localparam int CFG_INTDIM = 0;
    localparam int CFG_PHASE = 1;
    localparam int CFG_TWOPH = 2;
    localparam int CFG_CV = 3;
    localparam int CFG_DIV_LSB = 4;
    // channel config bits
    localparam int CH_EN = 0;
    localparam int CH_BLANK = 1;
    localparam int CH_FETEN = 2;
    localparam int CH_SLOPE_LSB = 4;
    localparam int CH_SS_LSB = 8;

    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [15:0] CHCFG_RST = 16'h0104;
    localparam logic [7:0] LIMIT_RST = 8'hff;
    localparam logic [7:0] SETPT_RST = 8'h00;
    localparam logic [7:0] SETPT_OFF_MAX = 8'h08;
    localparam logic [7:0] LIMIT_DIM_LOW = 8'hb3; // fixed ~700 mV code on the limit dac scale
    localparam logic [9:0] DIM_LOAD_CNT = 10'h3fe;
    localparam logic [9:0] DIM_HALF = 10'h200;
    localparam logic [7:0] RAMP_TOP = 8'hff;

    typedef enum logic [1:0] {
        SS_IDLE = 2'b00,
        SS_RAMP = 2'b01,
        SS_DONE = 2'b10
    } ldc_ss_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ldc_bus_s;

    typedef struct packed {
        logic gate;
        logic fet_on;
        logic comp_conn;
        logic blank;
        logic [7:0] limit_code;
        logic [2:0] slope;
        logic [7:0] setpoint;
        logic fb_select_cv;
        logic [7:0] ramp;
    } ldc_chout_s;
endpackage

// File: src/ldc_core.sv
/*
 * ldc_core: two-channel dimming counters, drive gating, blanking, current-limit select and soft start.
 * assumes the switching clock strobes, dimming pins and comparators come from outside and are synchronised here.
 */
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
//
// Notes on behaviour
// - blank current sense 150 ns or 75 ns at each cycle start, per-channel bit.
// - limit threshold is programmed setting while dimming high, fixed 700 mV while low.
// - sensed current over threshold ends gate and series-fet drive at once.
// - per-channel slope compensation field with seven levels.
// - constant-current mode regulates amplified led sense to 8-bit setpoint dac.
// - codes 9 to 255 give output; code 8 or below switches channel off.
// - constant-voltage mode regulates feedback pin with same code range and off rule.
// - internal dimming enable gives each channel a 10-bit counter, duty in two bytes.
// - high byte write is staged; low byte write makes both pending.
// - pending duty loads into compare only at count 1022.
// - dimming clock is main clock divided by 3-bit code; 001 is two; period 1024.
// - phase bit 0 runs channels 180 degrees apart, 1 in phase.
// - dimming low turns channel off, detaches compensation, holds fet off.
// - dimming rise re-enables drives; compensation reconnects once sense exceeds comp.
// - floating external dimming input reads low, disabling channel when internal off.
// - series-fet drive follows dimming and stays off when its enable is zero.
// - soft start steps 8-bit ramp from 0 to 255.
// - ramp counter clock is switching clock divided by soft-start factor plus one.
// - ramp begins only once the dimming signal is high.
// - ramp holds while dimming low and resumes from held value.
// - two-phase internal dimming uses the first channel's counter for both.
module ldc_core
    import ldc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire ldc_bus_s i_bus,
    output logic [15:0] o_rdata,
    input wire logic [1:0] i_sw_cycle_start,
    input wire logic [1:0] i_ext_dim,
    input wire logic [1:0] i_over_limit,
    input wire logic [1:0] i_sense_above_comp,
    output ldc_chout_s [1:0] o_ch
);
    // ********************************
    // input synchronisers
    // ********************************
    logic [1:0] cyc_m_q, cyc_s_q, cyc_p_q, dim_m_q, dim_s_q, lim_m_q, lim_s_q, cmp_m_q, cmp_s_q;
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            cyc_m_q <= 2'h0;
            cyc_s_q <= 2'h0;
            cyc_p_q <= 2'h0;
            dim_m_q <= 2'h0;
            dim_s_q <= 2'h0;
            lim_m_q <= 2'h0;
            lim_s_q <= 2'h0;
            cmp_m_q <= 2'h0;
            cmp_s_q <= 2'h0;
        end else begin
            cyc_m_q <= i_sw_cycle_start;
            cyc_s_q <= cyc_m_q;
            cyc_p_q <= cyc_s_q;
            dim_m_q <= i_ext_dim;
            dim_s_q <= dim_m_q;
            lim_m_q <= i_over_limit;
            lim_s_q <= lim_m_q;
            cmp_m_q <= i_sense_above_comp;
            cmp_s_q <= cmp_m_q;
        end
    end
    logic [1:0] cyc_rise;
    assign cyc_rise = cyc_s_q & ~cyc_p_q;

    // ********************************
    // registers
    // ********************************
    logic [7:0] cfg_q;
    logic [15:0] chcfg_q [2];
    logic [7:0] limit_q [2];
    logic [7:0] setpt_q [2];
    logic [1:0] stage_h_q [2];
    logic [9:0] pend_q [2];
    logic [15:0] rdata_q;
    logic [1:0] dim_ch;
    logic [1:0] ch_on;
    logic [1:0] gate_q, comp_q;
    ldc_ss_e ss_q [2];
    logic [7:0] ramp_q [2];

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            cfg_q <= CFG_RST;
        end else if (i_bus.wr && i_bus.addr == ADDR_CFG) begin
            cfg_q <= i_bus.wdata[7:0];
        end
    end

    // ********************************
    // dimming clock divider
    // ********************************
    // code n divides by 2^n; code 0 runs at the main clock
    logic [6:0] div_cnt_q;
    logic dim_tick;
    logic [2:0] div_code;
    assign div_code = cfg_q[CFG_DIV_LSB +: 3];
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            div_cnt_q <= 7'h00;
        end else begin
            div_cnt_q <= dim_tick ? 7'h00 : div_cnt_q + 7'h01;
        end
    end
    assign dim_tick = ({1'b0, div_cnt_q} == 8'((8'h01 << div_code) - 8'h01));

    // ********************************
    // per-channel logic
    // ********************************
    logic [9:0] dcnt_q [2];
    logic [9:0] act_q [2];
    logic [1:0] idim;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_ch
            localparam logic [7:0] BASE = 8'(ADDR_CH_BASE + g * ADDR_CH_STRIDE);
            logic sel_w;
            logic [3:0] blank_q;
            logic [7:0] ss_div_q;
            logic ss_tick;
            assign sel_w = i_bus.wr;

            always_ff @(posedge i_mclk) begin
                if (i_sys_rst) begin
                    chcfg_q[g] <= CHCFG_RST;
                    limit_q[g] <= LIMIT_RST;
                    setpt_q[g] <= SETPT_RST;
                    stage_h_q[g] <= 2'h0;
                    pend_q[g] <= 10'h000;
                end else if (sel_w) begin
                    if (i_bus.addr == BASE + OFS_CHCFG) chcfg_q[g] <= i_bus.wdata;
                    if (i_bus.addr == BASE + OFS_LIMIT) limit_q[g] <= i_bus.wdata[7:0];
                    if (i_bus.addr == BASE + OFS_SETPT) setpt_q[g] <= i_bus.wdata[7:0];
                    if (i_bus.addr == BASE + OFS_DUTYH) stage_h_q[g] <= i_bus.wdata[1:0];
                    if (i_bus.addr == BASE + OFS_DUTYL) pend_q[g] <= {stage_h_q[g], i_bus.wdata[7:0]};
                end
            end

            // counter; second channel starts half a period late unless in phase
            always_ff @(posedge i_mclk) begin
                if (i_sys_rst) begin
                    dcnt_q[g] <= (g == 1) ? DIM_HALF : 10'h000;
                    act_q[g] <= 10'h000;
                end else begin
                    if (g == 1 && cfg_q[CFG_PHASE] && dcnt_q[1] != dcnt_q[0]) begin
                        dcnt_q[g] <= dcnt_q[0] + {9'h000, dim_tick};
                    end else if (g == 1 && !cfg_q[CFG_PHASE] && dcnt_q[1] != dcnt_q[0] + DIM_HALF) begin
                        dcnt_q[g] <= dcnt_q[0] + DIM_HALF + {9'h000, dim_tick};
                    end else if (dim_tick) begin
                        dcnt_q[g] <= dcnt_q[g] + 10'h001;
                    end
                    if (dim_tick && dcnt_q[g] == DIM_LOAD_CNT) begin
                        act_q[g] <= pend_q[g];
                    end
                end
            end
            assign idim[g] = dcnt_q[g] < act_q[g];

            // blanking timer
            always_ff @(posedge i_mclk) begin
                if (i_sys_rst) begin
                    blank_q <= 4'h0;
                end else if (cyc_rise[g]) begin
                    blank_q <= chcfg_q[g][CH_BLANK] ? BLANK_SHORT_CNT : BLANK_LONG_CNT;
                end else if (blank_q != 4'h0) begin
                    blank_q <= blank_q - 4'h1;
                end
            end

            // gate: set at cycle start, ended by current limit or dimming low
            always_ff @(posedge i_mclk) begin
                if (i_sys_rst) begin
                    gate_q[g] <= 1'b0;
                    comp_q[g] <= 1'b0;
                end else begin
                    if (!ch_on[g] || !dim_ch[g]) begin
                        gate_q[g] <= 1'b0;
                    end else if (cyc_rise[g]) begin
                        gate_q[g] <= 1'b1;
                    end else if (lim_s_q[g] && blank_q == 4'h0) begin
                        gate_q[g] <= 1'b0;
                    end
                    if (!dim_ch[g]) begin
                        comp_q[g] <= 1'b0;
                    end else if (cmp_s_q[g]) begin
                        comp_q[g] <= 1'b1;
                    end
                end
            end

            // soft start
            always_ff @(posedge i_mclk) begin
                if (i_sys_rst) begin
                    ss_div_q <= 8'h00;
                end else if (cyc_rise[g]) begin
                    ss_div_q <= ss_tick ? 8'h00 : ss_div_q + 8'h01;
                end
            end
            assign ss_tick = cyc_rise[g] && ss_div_q == chcfg_q[g][CH_SS_LSB +: 8];
            always_ff @(posedge i_mclk) begin
                if (i_sys_rst || !ch_on[g]) begin
                    ss_q[g] <= SS_IDLE;
                    ramp_q[g] <= 8'h00;
                end else begin
                    case (ss_q[g])
                        SS_IDLE: begin
                            if (dim_ch[g]) ss_q[g] <= SS_RAMP;
                        end
                        SS_RAMP: begin
                            if (ramp_q[g] == RAMP_TOP) begin
                                ss_q[g] <= SS_DONE;
                            end else if (ss_tick && dim_ch[g]) begin
                                ramp_q[g] <= ramp_q[g] + 8'h01;
                            end
                        end
                        SS_DONE: ss_q[g] <= SS_DONE;
                        default: ss_q[g] <= SS_IDLE;
                    endcase
                end
            end

            assign ch_on[g] = chcfg_q[g][CH_EN] && setpt_q[g] > SETPT_OFF_MAX;
            // drive outputs: gate and fet cut combinationally by the synced limit so no extra cycle is lost
            assign o_ch[g].gate = gate_q[g] && !(lim_s_q[g] && blank_q == 4'h0);
            assign o_ch[g].fet_on = chcfg_q[g][CH_FETEN] && dim_ch[g] && ch_on[g]
                && !(lim_s_q[g] && blank_q == 4'h0);
            assign o_ch[g].comp_conn = comp_q[g];
            assign o_ch[g].blank = blank_q != 4'h0;
            assign o_ch[g].limit_code = dim_ch[g] ? limit_q[g] : LIMIT_DIM_LOW;
            assign o_ch[g].slope = chcfg_q[g][CH_SLOPE_LSB +: 3] == 3'h0 ? 3'h1 : chcfg_q[g][CH_SLOPE_LSB +: 3];
            assign o_ch[g].setpoint = setpt_q[g];
            assign o_ch[g].fb_select_cv = cfg_q[CFG_CV];
            assign o_ch[g].ramp = ramp_q[g];
        end
    endgenerate

    // dimming source per channel; two-phase shares the first counter
    assign dim_ch[0] = cfg_q[CFG_INTDIM] ? idim[0] : dim_s_q[0];
    assign dim_ch[1] = cfg_q[CFG_INTDIM] ? (cfg_q[CFG_TWOPH] ? idim[0] : idim[1]) : dim_s_q[1];

    // ********************************
    // read port
    // ********************************
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            rdata_q <= 16'h0000;
        end else if (i_bus.rd) begin
            case (i_bus.addr)
                ADDR_CFG: rdata_q <= {8'h00, cfg_q};
                ADDR_CH_BASE + OFS_CHCFG: rdata_q <= chcfg_q[0];
                ADDR_CH_BASE + OFS_LIMIT: rdata_q <= {8'h00, limit_q[0]};
                ADDR_CH_BASE + OFS_SETPT: rdata_q <= {8'h00, setpt_q[0]};
                ADDR_CH_BASE + OFS_DUTYH: rdata_q <= {14'h0000, pend_q[0][9:8]};
                ADDR_CH_BASE + OFS_DUTYL: rdata_q <= {8'h00, pend_q[0][7:0]};
                ADDR_CH_BASE + OFS_STATUS: rdata_q <= {ramp_q[0], 3'h0, ss_q[0], dim_ch[0], gate_q[0], comp_q[0]};
                ADDR_CH_BASE + ADDR_CH_STRIDE + OFS_CHCFG: rdata_q <= chcfg_q[1];
                ADDR_CH_BASE + ADDR_CH_STRIDE + OFS_LIMIT: rdata_q <= {8'h00, limit_q[1]};
                ADDR_CH_BASE + ADDR_CH_STRIDE + OFS_SETPT: rdata_q <= {8'h00, setpt_q[1]};
                ADDR_CH_BASE + ADDR_CH_STRIDE + OFS_DUTYH: rdata_q <= {14'h0000, pend_q[1][9:8]};
                ADDR_CH_BASE + ADDR_CH_STRIDE + OFS_DUTYL: rdata_q <= {8'h00, pend_q[1][7:0]};
                ADDR_CH_BASE + ADDR_CH_STRIDE + OFS_STATUS: rdata_q <= {ramp_q[1], 3'h0, ss_q[1], dim_ch[1], gate_q[1], comp_q[1]};
                default: rdata_q <= 16'h0000;
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end
    assign o_rdata = rdata_q;

    // ********************************
    // checks
    // ********************************
    a_duty_load_point: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        $changed(act_q[0]) |-> $past(dcnt_q[0]) == DIM_LOAD_CNT) else $error("duty loaded off 1022");
    a_dim_start: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        cfg_q[CFG_INTDIM] && dcnt_q[0] == 10'h000 && act_q[0] != 10'h000 |-> dim_ch[0])
        else $error("dim low at period start");
    a_phase_same: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        cfg_q[CFG_PHASE] |=> dcnt_q[1] == dcnt_q[0]) else $error("counters not in phase");
    a_phase_apart: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        !cfg_q[CFG_PHASE] |=> dcnt_q[1] == 10'(dcnt_q[0] + DIM_HALF)) else $error("counters not apart");
    a_limit_cuts: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        lim_s_q[0] && !o_ch[0].blank |-> !o_ch[0].gate && !o_ch[0].fet_on) else $error("limit not obeyed");
    a_limit_low: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        !dim_ch[0] |-> o_ch[0].limit_code == LIMIT_DIM_LOW) else $error("low limit wrong");
    a_off_code: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        setpt_q[0] <= SETPT_OFF_MAX |=> !gate_q[0]) else $error("channel not off");
    a_dim_off: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        !dim_ch[0] |=> !gate_q[0] && !comp_q[0]) else $error("dim low not off");
    a_ramp_hold: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        !dim_ch[0] && ch_on[0] |=> $stable(ramp_q[0])) else $error("ramp moved");
    a_ramp_start: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        ss_q[0] == SS_IDLE && !dim_ch[0] && ch_on[0] |=> ss_q[0] == SS_IDLE) else $error("ramp early");
    a_fet_enable: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        !chcfg_q[0][CH_FETEN] |-> !o_ch[0].fet_on) else $error("fet on while disabled");
    a_blank_len: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        cyc_rise[0] && !chcfg_q[0][CH_BLANK] |=> o_ch[0].blank [*3]) else $error("blank too short");
endmodule

// File: verif/ldc_stage_model.sv
/*
 * ldc_stage_model: behavioural power stage behind both channels (switching clock, switch current, comparators).
 * assumes the channel outputs of ldc_core; i_mode picks quiet (0), slow (2) or stuck over-limit (3) response.
 */
`timescale 1ns/1ps
module ldc_stage_model
    import ldc_pkg::*;
(
    input wire logic i_mclk,
    input wire ldc_chout_s [1:0] i_ch,
    input wire logic [1:0] i_mode,
    output logic [1:0] o_sw_cycle_start,
    output logic [1:0] o_over_limit,
    output logic [1:0] o_sense_above_comp
);
    // ********************************
    // switching clock
    // ********************************
    // runs free and out of phase with the main clock, so the design's synchronisers really work
    initial begin
        o_sw_cycle_start = 2'b00;
        #13;
        forever begin
            #400 o_sw_cycle_start = ~o_sw_cycle_start;
        end
    end

    // ********************************
    // inductor current and comparators
    // ********************************
    int cur [2];
    always_ff @(posedge i_mclk) begin
        for (int n = 0; n < 2; n++) begin
            cur[n] <= i_ch[n].gate ? cur[n] + 1 : 0;
        end
    end
    // slow mode: current climbs late past comp and trips the limit late; quiet mode never trips it
    always_comb begin
        for (int n = 0; n < 2; n++) begin
            o_over_limit[n] = (i_mode == 2'd3) || (i_mode == 2'd2 && cur[n] > 12);
            o_sense_above_comp[n] = i_ch[n].gate && (cur[n] > (i_mode == 2'd2 ? 8 : 2));
        end
    end
endmodule

// File: verif/ldc_core_tb.sv
/*
 * ldc_core_tb: self-checking bench for ldc_core, register port tasks plus counted output windows.
 * assumes the stage model for the far side; external dimming pins are driven by the bench.
 */
`timescale 1ns/1ps
module ldc_core_tb;
    import ldc_pkg::*;
    logic i_mclk;
    logic i_sys_rst;
    ldc_bus_s bus;
    logic [15:0] rdata;
    logic [1:0] sw;
    logic [1:0] ext_dim;
    logic [1:0] ovl;
    logic [1:0] sac;
    logic [1:0] mode;
    ldc_chout_s [1:0] ch;
    logic [3:0] probe;
    int mismatches;
    int total_checks;
    int c;
    int f;
    int s;
    logic [7:0] r;

    ldc_core dut_u(.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_bus(bus), .o_rdata(rdata), .i_sw_cycle_start(sw),
        .i_ext_dim(ext_dim), .i_over_limit(ovl), .i_sense_above_comp(sac), .o_ch(ch));
    ldc_stage_model stage_u(.i_mclk(i_mclk), .i_ch(ch), .i_mode(mode), .o_sw_cycle_start(sw),
        .o_over_limit(ovl), .o_sense_above_comp(sac));

    assign probe = {ch[0].fet_on & ch[1].fet_on, ch[1].fet_on, ch[0].fet_on, ch[0].gate};

    // ********************************
    // helpers
    // ********************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [7:0] cha(input int n, input logic [7:0] ofs);
        return ADDR_CH_BASE + 8'(n) * ADDR_CH_STRIDE + ofs;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_mclk);
        bus <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge i_mclk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge i_mclk);
        bus <= '0;
        #1;
        check("read data", rdata, exp);
    endtask

    // counts cycles in which the probed output is high; whole periods make the count phase-proof
    task automatic count_hi(input int n, input int sel, output int cnt);
        cnt = 0;
        repeat (n) begin
            @(posedge i_mclk);
            #1;
            cnt += int'(probe[sel] === 1'b1);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        i_mclk = 1'b0;
        forever begin
            #25 i_mclk = ~i_mclk;
        end
    end

    initial begin
        repeat (60000) @(posedge i_mclk);
        mismatches++;
        give_verdict();
    end

    // ********************************
    // tests
    // ********************************
    initial begin
        bus = '0;
        ext_dim = 2'b00;
        mode = 2'd0;
        i_sys_rst = 1'b1;
        mismatches = 0;
        total_checks = 0;
        repeat (12) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        @(posedge i_mclk);
        #1;
        check("limit at reset", 16'(ch[0].limit_code), 16'(LIMIT_DIM_LOW));
        check("ramp at reset", 16'(ch[0].ramp), 16'h0000);
        check("blank at reset", 16'(ch[0].blank), 16'h0000);
        rd(ADDR_CFG, {8'h00, CFG_RST});
        rd(cha(0, OFS_CHCFG), CHCFG_RST);
        rd(cha(0, OFS_LIMIT), {8'h00, LIMIT_RST});
        rd(cha(0, OFS_SETPT), {8'h00, SETPT_RST});
        rd(8'hf0, 16'h0000);
        wr(cha(0, OFS_CHCFG), 16'h0105);
        wr(cha(0, OFS_SETPT), 16'h0040);
        count_hi(64, 0, c);
        check("gate pin low", 16'(c), 16'h0000);
        check("ramp before dim", 16'(ch[0].ramp), 16'h0000);
        @(posedge i_mclk);
        mode <= 2'd2;
        ext_dim <= 2'b01;
        repeat (4) @(posedge i_mclk);
        #1;
        check("comp early", 16'(ch[0].comp_conn), 16'h0000);
        count_hi(96, 0, c);
        check("gate after rise", 16'(c > 0), 16'h0001);
        check("comp late", 16'(ch[0].comp_conn), 16'h0001);
        check("limit dim high", 16'(ch[0].limit_code), {8'h00, LIMIT_RST});
        @(posedge i_mclk);
        ext_dim <= 2'b00;
        repeat (8) @(posedge i_mclk);
        #1;
        r = ch[0].ramp;
        check("ramp stepped", 16'(r > 0), 16'h0001);
        check("fet dim low", 16'(ch[0].fet_on), 16'h0000);
        check("comp dim low", 16'(ch[0].comp_conn), 16'h0000);
        check("limit dim low", 16'(ch[0].limit_code), 16'(LIMIT_DIM_LOW));
        count_hi(64, 0, c);
        check("gate dim low", 16'(c), 16'h0000);
        check("ramp held", 16'(ch[0].ramp), 16'(r));
        @(posedge i_mclk);
        ext_dim <= 2'b01;
        mode <= 2'd0;
        repeat (96) @(posedge i_mclk);
        #1;
        check("ramp resumes", 16'(ch[0].ramp > r), 16'h0001);
        // limit stuck high: each pulse lasts only the blanking window
        @(posedge i_mclk);
        mode <= 2'd3;
        count_hi(64, 0, c);
        count_hi(64, 1, f);
        wr(cha(0, OFS_CHCFG), 16'h0107);
        count_hi(64, 0, s);
        check("gate cut", 16'(c < 32), 16'h0001);
        check("fet cut", 16'(f < 32), 16'h0001);
        check("short blank", 16'(s < c && s > 0), 16'h0001);
        @(posedge i_mclk);
        mode <= 2'd0;
        wr(cha(0, OFS_CHCFG), 16'h0105);
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_CFG, k[1] ? 16'h0008 : 16'h0000);
            wr(cha(0, OFS_SETPT), k[0] ? 16'h0009 : 16'h0008);
            count_hi(64, 0, c);
            check("gate vs setpoint", 16'(c > 0), 16'(k[0]));
            check("feedback select", 16'(ch[0].fb_select_cv), 16'(k[1]));
            check("setpoint out", 16'(ch[0].setpoint), k[0] ? 16'h0009 : 16'h0008);
        end
        for (int k = 0; k < 8; k++) begin
            wr(cha(0, OFS_CHCFG), 16'h0101 | 16'(k << 4));
            @(posedge i_mclk);
            #1;
            check("slope level", 16'(ch[0].slope), 16'(k == 0 ? 1 : k));
        end
        count_hi(64, 1, c);
        check("fet disabled", 16'(c), 16'h0000);
        count_hi(64, 0, c);
        check("gate fet disabled", 16'(c > 0), 16'h0001);
        // internal dimming, first undivided with channels 180 degrees apart, then in phase, staged duty, divided clock and two-phase
        @(posedge i_mclk);
        ext_dim <= 2'b00;
        for (int n = 0; n < 2; n++) begin
            wr(cha(n, OFS_CHCFG), 16'h0105);
            wr(cha(n, OFS_SETPT), 16'h0040);
            wr(cha(n, OFS_DUTYH), 16'h0002);
            wr(cha(n, OFS_DUTYL), 16'h0000);
        end
        wr(ADDR_CFG, 16'h0001);
        repeat (2100) @(posedge i_mclk);
        count_hi(1024, 1, c);
        check("half duty", 16'(c), 16'd512);
        count_hi(1024, 3, c);
        check("overlap apart", 16'(c), 16'd0);
        wr(ADDR_CFG, 16'h0003);
        repeat (2100) @(posedge i_mclk);
        count_hi(1024, 3, c);
        check("overlap in phase", 16'(c), 16'd512);
        wr(cha(0, OFS_DUTYH), 16'h0001);
        repeat (2100) @(posedge i_mclk);
        rd(cha(0, OFS_DUTYH), 16'h0002);
        count_hi(1024, 1, c);
        check("staged only", 16'(c), 16'd512);
        wr(cha(0, OFS_DUTYL), 16'h0000);
        rd(cha(0, OFS_DUTYH), 16'h0001);
        repeat (2100) @(posedge i_mclk);
        count_hi(1024, 1, c);
        check("new duty", 16'(c), 16'd256);
        wr(ADDR_CFG, 16'h0013);
        repeat (4200) @(posedge i_mclk);
        count_hi(2048, 1, c);
        check("divided period", 16'(c), 16'd512);
        wr(ADDR_CFG, 16'h0017);
        repeat (4200) @(posedge i_mclk);
        count_hi(2048, 2, c);
        check("two phase duty", 16'(c), 16'd512);
        give_verdict();
    end
endmodule
